// ---- phyctl_pkg.sv ----
// phyctl_pkg: constants, states and carrier types of the phy control register block.
// assumes one 100 MHz clock; all users name items as phyctl_pkg::name.
package phyctl_pkg;
    // management addressing
    localparam logic [4:0] PHYCTL_PHY_ADDR = 5'h00; // this device's phy address
    localparam logic [4:0] PHYCTL_CTRL_ADDR = 5'h00; // control register address
    localparam logic [1:0] PHYCTL_OP_READ = 2'h2;
    localparam logic [1:0] PHYCTL_OP_WRITE = 2'h1;
    localparam logic [4:0] PHYCTL_HDR_LAST = 5'h0C; // 13 header bits after the start zero
    localparam logic [4:0] PHYCTL_DATA_LAST = 5'h0F; // 16 data bits
    // control register layout and value after reset
    localparam logic [15:0] PHYCTL_CTRL_RESET = 16'h3100;
    localparam int PHYCTL_B_RESET = 15;
    localparam int PHYCTL_B_LOOP = 14;
    localparam int PHYCTL_B_RATE = 13;
    localparam int PHYCTL_B_AN = 12;
    localparam int PHYCTL_B_LP = 11;
    localparam int PHYCTL_B_ISO = 10;
    localparam int PHYCTL_B_RESTART = 9;
    localparam int PHYCTL_B_DUPLEX = 8;
    localparam int PHYCTL_B_COLLISION_TEST_ENABLE = 7;
    localparam int PHYCTL_RSV_MSB = 6;
    // soft reset sequence length
    localparam int PHYCTL_CLK_PERIOD_NS = 10;
    localparam int PHYCTL_SRST_TIME_NS = 1000;
    localparam int PHYCTL_SRST_CYCLES_I =
        (PHYCTL_SRST_TIME_NS + PHYCTL_CLK_PERIOD_NS - 1) / PHYCTL_CLK_PERIOD_NS;
    localparam logic [7:0] PHYCTL_SRST_CYCLES = 8'(PHYCTL_SRST_CYCLES_I);

    // management frame engine states
    typedef enum logic [3:0] {
        PHYCTL_ST_IDLE = 4'h1,
        PHYCTL_ST_HDR = 4'h2,
        PHYCTL_ST_TA = 4'h4,
        PHYCTL_ST_DATA = 4'h8
    } phyctl_state_t;

    // one completed management write
    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [15:0] data;
    } phyctl_wr_t;

    // one nibble-wide data stream beat
    typedef struct packed {
        logic en;
        logic [3:0] d;
    } phyctl_nib_t;

    // stored control fields (self-clearing bits kept apart)
    typedef struct packed {
        logic loop;
        logic rate;
        logic an;
        logic lp;
        logic iso;
        logic dup;
        logic arm;
        logic [6:0] rsv;
    } phyctl_ctrl_t;
endpackage

// ---- phyctl_mdio.sv ----
// phyctl_mdio: serial management frame engine, slave end.
// assumes mdc and mdio_i synchronous to clk and mdc far slower than clk.
`timescale 1ns/1ps
module phyctl_mdio (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // management pins
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // register side
    output logic [4:0] reg_addr,
    input wire logic [15:0] rd_data,
    output phyctl_pkg::phyctl_wr_t wr
);
    phyctl_pkg::phyctl_state_t state_q;
    logic mdc_q;
    logic [4:0] cnt_q;
    logic [15:0] sh_q;
    logic rd_q;
    logic wr_q;
    logic [12:0] hdr;
    logic rise;
    logic hdr_ok;
    logic me;
    logic [4:0] reg_addr_q;

    // frame decode: header bit 12 is the second start bit
    assign rise = mdc & ~mdc_q;
    assign hdr = {sh_q[11:0], mdio_i};
    assign me = hdr[9:5] == phyctl_pkg::PHYCTL_PHY_ADDR;
    assign hdr_ok = hdr[12] & me;
    assign reg_addr = reg_addr_q;

    // bits are sampled and driven on the rising edge of mdc seen in clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
            mdc_q <= 1'b0;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            reg_addr_q <= 5'h00;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
            wr <= '0;
        end else begin
            mdc_q <= mdc;
            wr.valid <= 1'b0;
            if (rise) begin
                case (state_q)
                    phyctl_pkg::PHYCTL_ST_IDLE: begin
                        // idle ones, with or without preamble; a zero opens a frame
                        cnt_q <= 5'h00;
                        if (!mdio_i) begin
                            state_q <= phyctl_pkg::PHYCTL_ST_HDR;
                        end
                    end
                    phyctl_pkg::PHYCTL_ST_HDR: begin
                        sh_q <= {sh_q[14:0], mdio_i};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == phyctl_pkg::PHYCTL_HDR_LAST) begin
                            cnt_q <= 5'h00;
                            reg_addr_q <= hdr[4:0];
                            rd_q <= hdr_ok && hdr[11:10] == phyctl_pkg::PHYCTL_OP_READ;
                            wr_q <= hdr_ok && hdr[11:10] == phyctl_pkg::PHYCTL_OP_WRITE;
                            state_q <= hdr[12] ? phyctl_pkg::PHYCTL_ST_TA
                                               : phyctl_pkg::PHYCTL_ST_IDLE;
                        end
                    end
                    phyctl_pkg::PHYCTL_ST_TA: begin
                        // first turnaround bit: a read frame for this phy takes the line and drives zero
                        cnt_q <= cnt_q + 5'h01;
                        mdio_oe <= rd_q;
                        mdio_o <= 1'b0;
                        if (cnt_q != 5'h00) begin
                            cnt_q <= 5'h00;
                            mdio_o <= rd_q & rd_data[15];
                            sh_q <= {rd_data[14:0], 1'b0};
                            state_q <= phyctl_pkg::PHYCTL_ST_DATA;
                        end
                    end
                    phyctl_pkg::PHYCTL_ST_DATA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (rd_q) begin
                            mdio_o <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'b0};
                        end else begin
                            sh_q <= {sh_q[14:0], mdio_i};
                        end
                        if (cnt_q == phyctl_pkg::PHYCTL_DATA_LAST) begin
                            // release the line as the last bit is sampled
                            mdio_oe <= 1'b0;
                            mdio_o <= 1'b0;
                            state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
                            wr.valid <= wr_q;
                            wr.addr <= reg_addr_q;
                            wr.data <= {sh_q[14:0], mdio_i};
                        end
                    end
                    default: begin
                        state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
                        mdio_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // phyctl_mdio

// ---- phyctl_top.sv ----
// phyctl_top: phy control register reached over the serial management pins,
// and the mode logic it steers on the nibble data paths.
// assumes all inputs synchronous to clk; negotiation outcome comes from outside.
//
// Summary of operation
// - The control register sits at management address zero and resets to 0x3100.
// - Writing one to bit 15 resets the registers and state, and the bit clears when done.
// - While bit 14 is set and bits 11 and 10 are clear, the receive path carries the own transmit data, not the line.
// - While bit 12 is set auto-negotiation runs; clearing it disables negotiation.
// - While bit 11 is set the device is in low power and ignores its data inputs, except that mac_tx.en still drives collision while bit 7 is set.
// - While bit 10 is set the transmit path is isolated and offered data is ignored.
// - Setting bit 7 places the device in collision test mode.
// - Bit 7 reads set once a transmission has begun and zero once it halts.
`timescale 1ns/1ps
module phyctl_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // management pins
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // mac side stream
    input wire phyctl_pkg::phyctl_nib_t mac_tx,
    output phyctl_pkg::phyctl_nib_t mac_rx,
    output logic collision,
    // line side stream
    input wire phyctl_pkg::phyctl_nib_t line_rx,
    output phyctl_pkg::phyctl_nib_t line_tx,
    // negotiation outcome
    input wire logic an_rate_100,
    input wire logic an_full_duplex,
    // mode outputs
    output logic loopback_enable,
    output logic low_power_enable,
    output logic isolate_enable,
    output logic autoneg_enable,
    output logic autoneg_restart,
    output logic rate_100,
    output logic full_duplex,
    output logic soft_reset_busy
);
    localparam phyctl_pkg::phyctl_ctrl_t CTRL_INIT = '{
        loop: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_LOOP],
        rate: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_RATE],
        an: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_AN],
        lp: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_LP],
        iso: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_ISO],
        dup: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_DUPLEX],
        arm: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_B_COLLISION_TEST_ENABLE],
        rsv: phyctl_pkg::PHYCTL_CTRL_RESET[phyctl_pkg::PHYCTL_RSV_MSB:0]
    };

    logic rst_s1_q;
    logic rst_s2_q;
    phyctl_pkg::phyctl_ctrl_t ctrl_q;
    phyctl_pkg::phyctl_ctrl_t ctrl_d;
    phyctl_pkg::phyctl_ctrl_t ctrl_wr;
    logic [7:0] srst_cnt_q;
    logic [7:0] srst_cnt_d;
    logic restart_q;
    logic tx_act_q;
    logic collision_test_enable_act_q;
    phyctl_pkg::phyctl_wr_t wr;
    logic [4:0] reg_addr;
    logic [15:0] ctrl_rd;
    logic [15:0] rd_data;
    logic wr_hit;
    logic srst_busy;
    logic srst_start;
    logic tx_halt;
    logic tx_blocked;
    phyctl_pkg::phyctl_nib_t line_tx_d;
    phyctl_pkg::phyctl_nib_t mac_rx_d;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // serial management engine
    phyctl_mdio u_mdio (
        .clk(clk),
        .rst_n(rst_s2_q),
        .mdc(mdc),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe(mdio_oe),
        .reg_addr(reg_addr),
        .rd_data(rd_data),
        .wr(wr)
    );

    // address decode; unmapped addresses read as zero and ignore writes
    assign wr_hit = wr.valid && wr.addr == phyctl_pkg::PHYCTL_CTRL_ADDR;
    assign srst_busy = srst_cnt_q != 8'h00;
    assign srst_start = wr_hit & wr.data[phyctl_pkg::PHYCTL_B_RESET] & ~srst_busy;
    assign tx_halt = tx_act_q & ~mac_tx.en;
    assign ctrl_rd = {srst_busy, ctrl_q.loop, ctrl_q.rate, ctrl_q.an, ctrl_q.lp,
                      ctrl_q.iso, restart_q, ctrl_q.dup, collision_test_enable_act_q, ctrl_q.rsv};
    assign rd_data = reg_addr == phyctl_pkg::PHYCTL_CTRL_ADDR ? ctrl_rd : 16'h0000;

    // field image of a management write
    assign ctrl_wr = '{
        loop: wr.data[phyctl_pkg::PHYCTL_B_LOOP],
        rate: wr.data[phyctl_pkg::PHYCTL_B_RATE],
        an: wr.data[phyctl_pkg::PHYCTL_B_AN],
        lp: wr.data[phyctl_pkg::PHYCTL_B_LP],
        iso: wr.data[phyctl_pkg::PHYCTL_B_ISO],
        dup: wr.data[phyctl_pkg::PHYCTL_B_DUPLEX],
        arm: wr.data[phyctl_pkg::PHYCTL_B_COLLISION_TEST_ENABLE],
        rsv: wr.data[phyctl_pkg::PHYCTL_RSV_MSB:0]
    };

    // next control value; writes during a soft reset are dropped so the
    // sequence always ends with the reset image in place
    always_comb begin
        ctrl_d = ctrl_q;
        srst_cnt_d = srst_busy ? srst_cnt_q - 8'h01 : 8'h00;
        if (srst_start) begin
            ctrl_d = CTRL_INIT;
            srst_cnt_d = phyctl_pkg::PHYCTL_SRST_CYCLES;
        end else if (srst_busy) begin
            ctrl_d = CTRL_INIT;
        end else begin
            // a finished transmission ends the collision test, but a write
            // arriving in the same cycle wins
            if (tx_halt) begin
                ctrl_d.arm = 1'b0;
            end
            if (wr_hit) begin
                ctrl_d = ctrl_wr;
            end
        end
    end

    // control register, soft reset counter and collision test tracking
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            ctrl_q <= CTRL_INIT;
            srst_cnt_q <= 8'h00;
            restart_q <= 1'b0;
            tx_act_q <= 1'b0;
            collision_test_enable_act_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            srst_cnt_q <= srst_cnt_d;
            // restart bit is held one cycle then clears itself
            restart_q <= wr_hit & ~srst_busy & ~srst_start
                         & wr.data[phyctl_pkg::PHYCTL_B_RESTART];
            tx_act_q <= mac_tx.en & ~srst_busy;
            collision_test_enable_act_q <= ctrl_d.arm & mac_tx.en & ~srst_busy;
        end
    end

    // data path steering; isolate, low power and loopback all keep the
    // mac's transmit data off the line
    assign tx_blocked = ctrl_q.iso | ctrl_q.lp | ctrl_q.loop | srst_busy;
    assign line_tx_d = tx_blocked ? '0 : mac_tx;
    always_comb begin
        mac_rx_d = line_rx;
        if (ctrl_q.lp || srst_busy) begin
            mac_rx_d = '0;
        end else if (ctrl_q.loop) begin
            mac_rx_d = ctrl_q.iso ? '0 : mac_tx;
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            line_tx <= '0;
            mac_rx <= '0;
            collision <= 1'b0;
            loopback_enable <= 1'b0;
            low_power_enable <= 1'b0;
            isolate_enable <= 1'b0;
            autoneg_enable <= 1'b0;
            autoneg_restart <= 1'b0;
            rate_100 <= 1'b0;
            full_duplex <= 1'b0;
            soft_reset_busy <= 1'b0;
        end else begin
            line_tx <= line_tx_d;
            mac_rx <= mac_rx_d;
            collision <= collision_test_enable_act_q & mac_tx.en;
            loopback_enable <= ctrl_q.loop;
            low_power_enable <= ctrl_q.lp;
            isolate_enable <= ctrl_q.iso;
            autoneg_enable <= ctrl_q.an;
            autoneg_restart <= restart_q & ctrl_q.an;
            rate_100 <= ctrl_q.an ? an_rate_100 : ctrl_q.rate;
            full_duplex <= ctrl_q.an ? an_full_duplex : ctrl_q.dup;
            soft_reset_busy <= srst_busy;
        end
    end
endmodule // phyctl_top

// ---- phyctl_mdio_fix.sv ----
// phyctl_mdio_fix: holds no logic; the management engine lives in phyctl_mdio.sv.

// ---- phyctl_top_monitor.sv ----
// phyctl_top_monitor: port-level assertions on the control register block.
// assumes it is bound onto phyctl_top; one clock, async active-low reset.
`timescale 1ns/1ps
module phyctl_top_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic mdio_o,
    input wire logic mdio_oe,
    input wire phyctl_pkg::phyctl_nib_t mac_tx,
    input wire phyctl_pkg::phyctl_nib_t mac_rx,
    input wire logic collision,
    input wire phyctl_pkg::phyctl_nib_t line_tx,
    input wire logic an_rate_100,
    input wire logic an_full_duplex,
    input wire logic loopback_enable,
    input wire logic low_power_enable,
    input wire logic isolate_enable,
    input wire logic autoneg_enable,
    input wire logic autoneg_restart,
    input wire logic rate_100,
    input wire logic full_duplex,
    input wire logic soft_reset_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] busy_q;
    logic [7:0] busy_d;
    logic lb_clean;
    // run length of soft reset, saturating so a stuck flag cannot wrap
    assign busy_d = !soft_reset_busy ? 8'h00 : (busy_q == 8'hFF ? busy_q : busy_q + 8'h01);
    assign lb_clean = loopback_enable && !isolate_enable && !low_power_enable && !soft_reset_busy;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 8'h00;
        end else begin
            busy_q <= busy_d;
        end
    end
    property p_reset_value;
        $rose(rst_n) |-> ##[1:8] (autoneg_enable && !loopback_enable && !low_power_enable);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad modes after reset");
    property p_ta_drive;
        $rose(mdio_oe) |-> !mdio_o ##1 mdio_oe [*8];
    endproperty
    a_ta_drive: assert property (p_ta_drive) else $error("read turnaround wrong");
    property p_srst_len;
        $fell(soft_reset_busy) |-> busy_q >= 8'h63 && busy_q <= 8'h65;
    endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
    property p_srst_bound;
        busy_q <= 8'h65;
    endproperty
    a_srst_bound: assert property (p_srst_bound) else $error("soft reset never ends");
    property p_srst_clear;
        $fell(soft_reset_busy) |-> ##[0:2] (autoneg_enable && !loopback_enable && !isolate_enable);
    endproperty
    a_srst_clear: assert property (p_srst_clear) else $error("modes kept over soft reset");
    property p_loop;
        lb_clean && $past(lb_clean) |-> mac_rx == $past(mac_tx);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback data wrong");
    property p_an_rate;
        autoneg_enable && $past(autoneg_enable) && !soft_reset_busy
            |-> rate_100 == $past(an_rate_100) && full_duplex == $past(an_full_duplex);
    endproperty
    a_an_rate: assert property (p_an_rate) else $error("negotiated mode ignored");
    property p_low_power;
        low_power_enable && $past(low_power_enable) |-> mac_rx == 5'h00 && line_tx == 5'h00;
    endproperty
    a_low_power: assert property (p_low_power) else $error("data moves in low power");
    property p_isolate;
        isolate_enable && $past(isolate_enable) |-> !line_tx.en;
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolated path transmits");
    property p_collision;
        collision |-> $past(mac_tx.en) || $past(mac_tx.en, 2);
    endproperty
    a_collision: assert property (p_collision) else $error("collision without transmit");
    property p_restart;
        autoneg_restart |-> autoneg_enable ##1 !autoneg_restart;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
endmodule // phyctl_top_monitor

bind phyctl_top phyctl_top_monitor phyctl_top_monitor_i (.clk, .rst_n, .mdio_o, .mdio_oe,
    .mac_tx, .mac_rx, .collision, .line_tx, .an_rate_100, .an_full_duplex, .loopback_enable,
    .low_power_enable, .isolate_enable, .autoneg_enable, .autoneg_restart, .rate_100,
    .full_duplex,
    .soft_reset_busy);

// ---- phyctl_mdio_host.sv ----
// phyctl_mdio_host: behavioural management master framing reads and writes.
// assumes the device pins on mdio_o/mdio_oe; the line has a pull-up when released.
`timescale 1ns/1ps
module phyctl_mdio_host #(
    parameter int HALF = 20 // 20 clk per half period, 41 clk per bit, keeps mdc near 2.44 MHz
) (
    // clock
    input wire logic clk,
    // device drive of the data line
    input wire logic mdio_o,
    input wire logic mdio_oe,
    // management pins
    output logic mdc,
    output logic mdio_i
);
    logic drv_q = 1'b0;
    logic bit_q = 1'b1;
    initial mdc = 1'b0;
    // wired line: device, then master, else the pull-up level
    assign mdio_i = mdio_oe ? mdio_o : (drv_q ? bit_q : 1'b1);
    // one 32-bit frame; mdc stays low between frames
    task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rdat);
        logic [31:0] f;
        f = {2'b01, rd ? phyctl_pkg::PHYCTL_OP_READ : phyctl_pkg::PHYCTL_OP_WRITE,
             phyctl_pkg::PHYCTL_PHY_ADDR, ra, 2'b10, wd & 16'hFF80};
        rdat = 16'h0000;
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk);
            drv_q <= !rd || i > 17; // reads release the line from the turnaround
            bit_q <= f[i];
            repeat (HALF) @(posedge clk);
            mdc <= 1'b1;
            if (i < 16) rdat = {rdat[14:0], mdio_i};
            repeat (HALF) @(posedge clk);
            mdc <= 1'b0;
        end
        @(posedge clk);
        drv_q <= 1'b0;
    endtask
endmodule // phyctl_mdio_host

// ---- testbench.sv ----
// testbench: exercises the control register block through the management master model.
// assumes phyctl_top, phyctl_mdio_host and the bound monitor are compiled first.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] wd;
        logic [15:0] rv;
        logic [5:0] md;
        logic [9:0] dp;
        logic [9:0] m;
    } phyctl_tb_row_t;
    logic clk, rst_n, mdc, mdio_i, mdio_o, mdio_oe, collision, an_rate_100, an_full_duplex;
    logic loopback_enable, low_power_enable, isolate_enable, autoneg_enable;
    logic rate_100, full_duplex, soft_reset_busy, autoneg_restart;
    logic [15:0] n_restart = 16'h0000;
    phyctl_pkg::phyctl_nib_t mac_tx, mac_rx, line_rx, line_tx;
    logic [15:0] rd;
    logic [5:0] modes;
    logic [9:0] dp;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    // write value, read value, modes {loop,lp,iso,an,rate,dup}, {mac_rx,line_tx}, mask
    phyctl_tb_row_t rows [7] = '{
        {16'h3100, 16'h3100, 6'h06, 10'h2BA, 10'h3FF},
        {16'h4000, 16'h4000, 6'h20, 10'h340, 10'h3E0},
        {16'h0800, 16'h0800, 6'h10, 10'h000, 10'h3FF},
        {16'h0400, 16'h0400, 6'h08, 10'h000, 10'h01F},
        {16'h2100, 16'h2100, 6'h03, 10'h2BA, 10'h3FF},
        {16'h1200, 16'h1000, 6'h06, 10'h2BA, 10'h3FF},
        {16'h0000, 16'h0000, 6'h00, 10'h2BA, 10'h3FF}};
    assign modes = {loopback_enable, low_power_enable, isolate_enable, autoneg_enable,
                    rate_100, full_duplex};
    assign dp = {mac_rx, line_tx};
    phyctl_top phyctl_top_i (.clk, .rst_n, .mdc, .mdio_i, .mdio_o, .mdio_oe, .mac_tx, .mac_rx,
        .collision, .line_rx, .line_tx, .an_rate_100, .an_full_duplex, .loopback_enable,
        .low_power_enable, .isolate_enable, .autoneg_enable, .autoneg_restart, .rate_100,
        .full_duplex, .soft_reset_busy);
    phyctl_mdio_host phyctl_mdio_host_i (.clk, .mdio_o, .mdio_oe, .mdc, .mdio_i);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // only the control address is ever written
    task automatic wr(input logic [15:0] d);
        phyctl_mdio_host_i.frame(1'b0, phyctl_pkg::PHYCTL_CTRL_ADDR, d, rd);
    endtask
    task automatic rdr(input logic [4:0] a);
        phyctl_mdio_host_i.frame(1'b1, a, 16'h0000, rd);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard: about 45 frames of some 1313 cycles each
    always @(posedge clk) begin
        cycles++;
        if (autoneg_restart === 1'b1) n_restart++;
        if (cycles == 32'h0000EA60) begin
            failures++;
            $display("MISMATCH timeout expected done seen hang");
            finish_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        mac_tx = 5'h00;
        line_rx = 5'h00;
        an_rate_100 = 1'b1;
        an_full_duplex = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdr(phyctl_pkg::PHYCTL_CTRL_ADDR);
        check("reset_read", 16'h3100, rd);
        for (int r = 0; r < 7; r++) begin
            wr(rows[r].wd);
            mac_tx <= 5'h1A;
            line_rx <= 5'h15;
            repeat (4) @(posedge clk);
            check("modes", {10'h000, rows[r].md}, {10'h000, modes});
            check("data", {6'h00, rows[r].dp & rows[r].m}, {6'h00, dp & rows[r].m});
            rdr(phyctl_pkg::PHYCTL_CTRL_ADDR);
            check("readback", rows[r].rv, rd);
            mac_tx <= 5'h00;
        end
        // only the row writing bit 9 with negotiation on may pulse restart
        check("restart", 16'h0001, n_restart);
        // collision test armed, then one transmission starts and halts
        wr(16'h0080);
        mac_tx <= 5'h1A;
        repeat (4) @(posedge clk);
        check("collision", 16'h0001, {15'h0000, collision});
        rdr(phyctl_pkg::PHYCTL_CTRL_ADDR);
        check("collision_test_enable_tx", 16'h0080, rd);
        mac_tx <= 5'h00;
        repeat (4) @(posedge clk);
        check("collision_off", 16'h0000, {15'h0000, collision});
        rdr(phyctl_pkg::PHYCTL_CTRL_ADDR);
        check("collision_test_enable_idle", 16'h0000, rd);
        // soft reset over a loopback setting, back to back frames
        wr(16'h4000);
        wr(16'h8000);
        check("busy", 16'h0001, {15'h0000, soft_reset_busy});
        for (int k = 0; k < 200 && soft_reset_busy !== 1'b0; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        check("srst_modes", 16'h0006, {10'h000, modes});
        rdr(phyctl_pkg::PHYCTL_CTRL_ADDR);
        check("srst_read", 16'h3100, rd);
        rdr(5'h05);
        check("unmapped", 16'h0000, rd);
        // second hardware reset in mid-run
        wr(16'h4800);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdr(phyctl_pkg::PHYCTL_CTRL_ADDR);
        check("rereset_read", 16'h3100, rd);
        finish_test();
    end
endmodule // testbench
